// *** src/vph_pkg.sv ***
// package: constants, offsets and types of the voice phrase host port
package vph_pkg;
   // ----------------------------------------------------------------
   // synchronised input vector layout
   // ----------------------------------------------------------------
   localparam int          SYNC_W      = 13;
   localparam int          IX_SDATA    = 6;    // line 6, serial data in serial mode
   localparam int          IX_SCLK     = 5;    // line 5, serial clock in serial mode
   localparam int          IX_GO       = 7;
   localparam int          IX_CMDQ     = 8;
   localparam int          IX_LANE     = 9;
   localparam int          IX_SERIAL   = 10;
   localparam int          IX_HOST     = 11;
   localparam int          IX_PGM      = 12;
   // strobe, qualifier and lane idle high (pulled up)
   localparam logic [12:0] SYNC_RST    = 13'h0380;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFF_STATUS   = 8'h00;
   localparam logic [7:0]  OFF_PHRASE   = 8'h04;
   localparam logic [7:0]  OFF_COMMAND  = 8'h08;
   localparam logic [7:0]  OFF_PLAY_LEN = 8'h0C;
   localparam logic [7:0]  OFF_STOP     = 8'h10;
   localparam logic [15:0] PLAY_LEN_RST = 16'h0100;

   // ----------------------------------------------------------------
   // serial word and command codes
   // ----------------------------------------------------------------
   localparam int          SER_CMD_BIT = 7;    // 1: command, 0: phrase address
   localparam int          CMD_OP_HI   = 6;
   localparam int          CMD_OP_LO   = 5;

   typedef enum logic [1:0] {
      CMD_ROUTE_DAC = 2'b00,
      CMD_ROUTE_LPF = 2'b01,
      CMD_SILENCE   = 2'b10,
      CMD_NONE      = 2'b11
   } vph_cmd_t;

   typedef enum logic [1:0] {
      PS_IDLE  = 2'b00,
      PS_PHRASE = 2'b01,
      PS_CMD   = 2'b10
   } vph_state_t;
endpackage

// *** src/vph_sync_if.sv ***
// interface: raw and synchronised host inputs
`timescale 1ns/1ps
`default_nettype none
interface vph_sync_if;
   logic [12:0] raw;
   logic [12:0] clean;
   modport syncer (input raw, output clean);
   modport user   (output raw, input clean);
endinterface
`default_nettype wire

// *** src/vph_sync.sv ***
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module vph_sync (
   // clock and reset
   input wire logic   pclk,
   input wire logic   presetn,
   // synchroniser side of the input carrier
   vph_sync_if.syncer sif
);
   logic [12:0] f1_r;
   logic [12:0] f2_r;
   logic [12:0] f3_r;
   logic [12:0] clean_r;

   // ----------------------------------------------------------------
   // chain; f1 feeds f2 only, a change counts once f2 and f3 agree
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f1_r    <= vph_pkg::SYNC_RST;
         f2_r    <= vph_pkg::SYNC_RST;
         f3_r    <= vph_pkg::SYNC_RST;
         clean_r <= vph_pkg::SYNC_RST;
      end else begin
         f1_r    <= sif.raw;
         f2_r    <= f1_r;
         f3_r    <= f2_r;
         clean_r <= (f2_r & f3_r) | (clean_r & (f2_r ^ f3_r));
      end
   end

   assign sif.clean = clean_r;
endmodule
`default_nettype wire

// *** src/vph_host_port.sv ***
// module: host command port of a two-channel phrase playback device
//
// Behaviour
// - reset low holds device in standby
// - reset stops oscillator, grounds speech, clears state
// - busy low during playback, high after reset
// - ready high when next address acceptable
// - qualifier and strobe ignored while ready low
// - in parallel mode, qualifier high at strobe fall means command
// - playback starts at strobe falling edge
// - lines latched as address at strobe rise
// - lane high picks channel 1, low 2
// - parallel lines carry commands and phrase codes
// - serial mode takes words on serial data
// - serial clock line is the bit clock
// - serial mode drives lines 2, 3 from silence code
// - command routes converter or filter to speech out
// - interface select high serial, low parallel
// - controller mode select high enables host port
`timescale 1ns/1ps
`default_nettype none
module vph_host_port (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // host strobe, qualifier and selects
   input  wire logic        go_pulse_n,
   input  wire logic        command_qualifier,
   input  wire logic        voice_lane_select,
   input  wire logic        serial_mode_sel,
   input  wire logic        host_mode_sel,
   input  wire logic        program_tool_pin,
   // phrase lines
   input  wire logic        serial_data_in,
   input  wire logic        serial_clock_in,
   input  wire logic        phrase_line4,
   input  wire logic [1:0]  phrase_lines_lo,
   // two-way lines 2 and 3
   input  wire logic        aux_out_a_i,
   output var  logic        aux_out_a_o,
   output var  logic        aux_out_a_oe_n,
   input  wire logic        aux_out_b_i,
   output var  logic        aux_out_b_o,
   output var  logic        aux_out_b_oe_n,
   // status pins and speech path control
   output var  logic        busy_n,
   output var  logic        addr_accept_ready,
   output var  logic        analog_speech_out_lpf,
   output var  logic        analog_speech_out_live,
   output var  logic        osc_run
);
   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   vph_sync_if sif ();

   // all pins pass the same three-stage chain, keeping their relative timing
   assign sif.raw = {program_tool_pin, host_mode_sel, serial_mode_sel, voice_lane_select,
                     command_qualifier, go_pulse_n, serial_data_in, serial_clock_in,
                     phrase_line4, aux_out_b_i, aux_out_a_i, phrase_lines_lo};

   vph_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .sif     (sif)
   );

   logic [12:0] s_d_r;

   // previous synchronised value for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_d_r <= vph_pkg::SYNC_RST;
      end else begin
         s_d_r <= sif.clean;
      end
   end

   // ----------------------------------------------------------------
   // edges, modes and the word on offer
   // ----------------------------------------------------------------
   wire       [12:0] s          = sif.clean;
   wire              go_fall    = s_d_r[vph_pkg::IX_GO] & ~s[vph_pkg::IX_GO];
   wire              go_rise    = ~s_d_r[vph_pkg::IX_GO] & s[vph_pkg::IX_GO];
   wire              ser_mode   = s[vph_pkg::IX_SERIAL];
   wire              host_on    = s[vph_pkg::IX_HOST];
   wire              sclk_rise  = ser_mode & ~s_d_r[vph_pkg::IX_SCLK] & s[vph_pkg::IX_SCLK];

   logic       [7:0] shift_r;
   vph_pkg::vph_state_t state_r;
   vph_pkg::vph_state_t state_nxt;
   logic             ready_r;

   // serial keeps the last 8 bits; lines 0, 1, 4 and the qualifier are unused then
   wire        [6:0] word       = ser_mode ? shift_r[6:0] : s[6:0];
   wire              is_cmd     = ser_mode ? shift_r[vph_pkg::SER_CMD_BIT]
                                           : s[vph_pkg::IX_CMDQ];
   wire              accept     = go_fall & host_on & ready_r & (state_r == vph_pkg::PS_IDLE);
   wire              latch_ph   = go_rise & (state_r == vph_pkg::PS_PHRASE);
   wire              latch_cmd  = go_rise & (state_r == vph_pkg::PS_CMD);
   wire        [1:0] cmd_op     = word[vph_pkg::CMD_OP_HI:vph_pkg::CMD_OP_LO];

   // serial shift, MSB first on each rising bit clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_r <= 8'h00;
      end else if (sclk_rise) begin
         shift_r <= {shift_r[6:0], s[vph_pkg::IX_SDATA]};
      end
   end

   // ----------------------------------------------------------------
   // strobe state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         vph_pkg::PS_IDLE: begin
            if (accept) begin
               state_nxt = is_cmd ? vph_pkg::PS_CMD : vph_pkg::PS_PHRASE;
            end
         end
         vph_pkg::PS_PHRASE, vph_pkg::PS_CMD: begin
            if (go_rise) begin
               state_nxt = vph_pkg::PS_IDLE;
            end
         end
         default: state_nxt = vph_pkg::PS_IDLE;
      endcase
   end

   // ready follows the state, so a strobe in progress blocks the next one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= vph_pkg::PS_IDLE;
         ready_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         ready_r <= (state_nxt == vph_pkg::PS_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // playback channels, one down-counter each
   // ----------------------------------------------------------------
   logic      [15:0] play_len_r;
   logic       [1:0] stop_req;
   logic       [1:0] chan_go;
   logic       [1:0] act_nxt;
   logic       [1:0] active;
   wire              lane       = s[vph_pkg::IX_LANE];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         logic [15:0] cnt_r;
         logic [15:0] cnt_nxt;
         // lane high selects channel 1 (index 0), low channel 2
         assign chan_go[g] = accept & ~is_cmd & (lane == (g == 0));
         // a start in the same cycle as a stop wins, so no fresh phrase is lost
         assign cnt_nxt    = chan_go[g]  ? play_len_r :
                             stop_req[g] ? 16'h0000 :
                             (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
         assign act_nxt[g] = (cnt_nxt != 16'h0000);
         assign active[g]  = (cnt_r != 16'h0000);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_r <= 16'h0000;
            end else begin
               cnt_r <= cnt_nxt;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // latched address, commands and pin outputs
   // ----------------------------------------------------------------
   logic       [6:0] phrase_r;
   logic             lane_r;
   logic       [6:0] command_r;
   logic             lpf_r;
   logic       [1:0] port_lvl_r;
   logic             busy_n_r;
   logic             live_r;
   logic             lane_at_fall_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phrase_r       <= 7'h00;
         lane_r         <= 1'b1;
         lane_at_fall_r <= 1'b1;
         command_r      <= 7'h00;
         lpf_r          <= 1'b0;
         port_lvl_r     <= 2'h0;
      end else begin
         if (accept) begin
            lane_at_fall_r <= lane;
         end
         if (latch_ph) begin
            phrase_r <= word;
            lane_r   <= lane_at_fall_r;
         end
         if (latch_cmd) begin
            command_r <= word;
            if (cmd_op == vph_pkg::CMD_ROUTE_DAC) begin
               lpf_r <= 1'b0;
            end else if (cmd_op == vph_pkg::CMD_ROUTE_LPF) begin
               lpf_r <= 1'b1;
            end else if (cmd_op == vph_pkg::CMD_SILENCE) begin
               port_lvl_r <= word[1:0];
            end
         end
      end
   end

   // pins: standby values in reset, released one edge after it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_n_r       <= 1'b1;
         live_r         <= 1'b0;
         aux_out_a_o    <= 1'b0;
         aux_out_b_o    <= 1'b0;
         aux_out_a_oe_n <= 1'b1;
         aux_out_b_oe_n <= 1'b1;
      end else begin
         busy_n_r       <= ~|act_nxt;
         live_r         <= 1'b1;
         aux_out_a_o    <= port_lvl_r[0];
         aux_out_b_o    <= port_lvl_r[1];
         aux_out_a_oe_n <= ~ser_mode;
         aux_out_b_oe_n <= ~ser_mode;
      end
   end

   assign busy_n                 = busy_n_r;
   assign addr_accept_ready      = ready_r;
   assign analog_speech_out_lpf  = lpf_r;
   assign analog_speech_out_live = live_r;
   assign osc_run                = live_r;

   // ----------------------------------------------------------------
   // apb slave, no wait states, yet read data leaves a flip-flop
   // ----------------------------------------------------------------
   function automatic logic vph_hit(input logic [7:0] a, input logic [7:0] off);
      vph_hit = (a == off);
   endfunction

   wire              setup      = psel & ~penable;
   wire              wr_done    = psel & penable & pready & pwrite & ~pslverr;
   wire              mapped     = vph_hit(paddr, vph_pkg::OFF_STATUS) | vph_hit(paddr, vph_pkg::OFF_PHRASE) |
                                  vph_hit(paddr, vph_pkg::OFF_COMMAND) | vph_hit(paddr, vph_pkg::OFF_PLAY_LEN) |
                                  vph_hit(paddr, vph_pkg::OFF_STOP);
   logic      [31:0] rd_mux;

   assign stop_req = (wr_done & vph_hit(paddr, vph_pkg::OFF_STOP)) ? pwdata[1:0] : 2'b00;

   // read selection
   always_comb begin
      if (vph_hit(paddr, vph_pkg::OFF_STATUS)) begin
         rd_mux = {22'h000000, port_lvl_r, s[vph_pkg::IX_PGM], lpf_r, active,
                   host_on, ser_mode, ready_r, busy_n_r};
      end else if (vph_hit(paddr, vph_pkg::OFF_PHRASE)) begin
         rd_mux = {23'h000000, lane_r, 1'b0, phrase_r};
      end else if (vph_hit(paddr, vph_pkg::OFF_COMMAND)) begin
         rd_mux = {25'h0000000, command_r};
      end else if (vph_hit(paddr, vph_pkg::OFF_PLAY_LEN)) begin
         rd_mux = {16'h0000, play_len_r};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   // answer registered in the setup cycle, taken at the first access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata     <= 32'h00000000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         play_len_r <= vph_pkg::PLAY_LEN_RST;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
         if (wr_done & vph_hit(paddr, vph_pkg::OFF_PLAY_LEN)) begin
            play_len_r <= pwdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_phrase_start;
      accept && !is_cmd;
   endsequence

   sequence s_strobe_open;
      state_r != vph_pkg::PS_IDLE;
   endsequence

   a_busy_on_start: assert property ((s_phrase_start and (play_len_r != 16'h0000)) |=> !busy_n)
      else $error("busy not low after strobe fall");
   a_busy_tracks: assert property (busy_n == !(|active))
      else $error("busy disagrees with channel activity");
   a_ready_blocked: assert property (s_strobe_open |-> !addr_accept_ready)
      else $error("ready high during strobe");
   a_ignore_strobe: assert property (!addr_accept_ready |-> !accept && chan_go == 2'b00)
      else $error("strobe taken while not ready");
   a_cmd_no_play: assert property (accept && is_cmd |-> chan_go == 2'b00 ##1 state_r == vph_pkg::PS_CMD)
      else $error("command started playback");
   a_addr_latch: assert property (latch_ph |=> phrase_r == $past(word) ##1 addr_accept_ready)
      else $error("phrase address not latched at strobe rise");
   a_lane_pick: assert property (s_phrase_start |-> chan_go == (lane ? 2'b01 : 2'b10))
      else $error("wrong channel chosen");
   a_serial_shift: assert property (sclk_rise |=> shift_r[0] == $past(s[vph_pkg::IX_SDATA]))
      else $error("serial bit not shifted");
   a_aux_drive: assert property (ser_mode [*2] |-> !aux_out_a_oe_n && !aux_out_b_oe_n)
      else $error("aux lines not driven in serial mode");
   a_route_lpf: assert property (latch_cmd && cmd_op == vph_pkg::CMD_ROUTE_LPF |=> analog_speech_out_lpf)
      else $error("filter route not applied");
endmodule
`default_nettype wire

// *** testbench/vph_host_model.sv ***
// host controller model driving strobe, qualifier, lane and phrase lines
`timescale 1ns/1ps
`default_nettype none
module vph_host_model (
   // clock and device status
   input  wire logic       pclk,
   input  wire logic       ready,
   input  wire logic       serial_mode,
   // strobe and selects
   output var  logic       go_n,
   output var  logic       cmd_q,
   output var  logic       lane,
   output var  logic       tool_pin,
   // phrase lines as the host drives them, and a missed-ready flag
   output var  logic [6:0] lines,
   output var  logic       stuck
);
   // idle levels of the host pins
   initial begin
      go_n = 1'b1;
      cmd_q = 1'b1;
      lane = 1'b1;
      tool_pin = 1'b0;
      lines = 7'h00;
      stuck = 1'b0;
   end

   // strobe fall once ready is seen high, or after 60 cycles with stuck set
   task automatic fall(input logic [6:0] a, input logic c, input logic l);
      int n;
      n = 0;
      @(posedge pclk);
      while (ready !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      stuck <= stuck | (n >= 60);
      if (!serial_mode) lines <= a;
      cmd_q <= c | serial_mode;
      lane <= l;
      go_n <= 1'b0;
   endtask

   // strobe rise; lines held past the rise, then released
   task automatic rise();
      @(posedge pclk);
      go_n <= 1'b1;
      repeat (12) @(posedge pclk);
      cmd_q <= 1'b1;
      // released lines: 0, 1 and 4 pulled down, the rest show the inverse
      if (!serial_mode) lines <= ~lines & 7'h6C;
   endtask

   // one serial word, msb first; bit clock stands low between frames
   task automatic ser(input logic [7:0] b);
      @(posedge pclk);
      lines <= 7'h00;
      #1.3;
      for (int i = 7; i >= 0; i--) begin
         lines[6] = b[i];
         #12 lines[5] = 1'b1;
         #24 lines[5] = 1'b0;
         #12;
      end
      lines[6] = ~b[0];
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench of the voice phrase host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        serial_mode_sel, host_mode_sel, go_n, cmd_q, lane, tool_pin, stuck;
   logic        a_o, a_oe_n, b_o, b_oe_n, a_w, b_w, busy_n, ready, lpf, live, osc, l, exp_lpf;
   logic [7:0]  paddr;
   logic [6:0]  lines, a;
   logic [31:0] pwdata, prdata, rd, seed;
   int          miscompares, samples_checked, cyc, t0, n;

   // lines 2 and 3: the port wins while its enable is low
   assign a_w = a_oe_n ? lines[2] : a_o;
   assign b_w = b_oe_n ? lines[3] : b_o;

   vph_host_port vph_host_port_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .go_pulse_n(go_n), .command_qualifier(cmd_q), .voice_lane_select(lane),
      .serial_mode_sel(serial_mode_sel), .host_mode_sel(host_mode_sel), .program_tool_pin(tool_pin),
      .serial_data_in(lines[6]), .serial_clock_in(lines[5]), .phrase_line4(lines[4]),
      .phrase_lines_lo(lines[1:0]), .aux_out_a_i(a_w), .aux_out_a_o(a_o), .aux_out_a_oe_n(a_oe_n),
      .aux_out_b_i(b_w), .aux_out_b_o(b_o), .aux_out_b_oe_n(b_oe_n), .busy_n(busy_n),
      .addr_accept_ready(ready), .analog_speech_out_lpf(lpf), .analog_speech_out_live(live),
      .osc_run(osc));

   vph_host_model vph_host_model_i (
      .pclk(pclk), .ready(ready), .serial_mode(serial_mode_sel), .go_n(go_n), .cmd_q(cmd_q),
      .lane(lane), .tool_pin(tool_pin), .lines(lines), .stuck(stuck));

   // clock and cycle count
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;

   // ----------------------------------------------------------------
   // expectations, checking and closing
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   function automatic logic [31:0] phrase_exp(input logic [6:0] pa, input logic pl);
      return {23'h000000, pl, 1'b0, pa};
   endfunction
   // only ops 00 and 01 move the speech route
   function automatic logic lpf_exp(input logic [1:0] op, input logic prev);
      return op[1] ? prev : op[0];
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one apb transfer, setup then access until pready
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         miscompares++;
         wrap_up();
      end
   endtask

   // full strobe; a phrase also checks playback and its channel
   task automatic strobe(input logic [6:0] sa, input logic c, input logic sl);
      vph_host_model_i.fall(sa, c, sl);
      t0 = cyc;
      repeat (8) @(posedge pclk);
      chk("ready_low", ready, 1'b0);
      if (!c) begin
         chk("busy_play", busy_n, 1'b0);
         apb(1'b0, vph_pkg::OFF_STATUS, 32'h0);
         chk("lane_active", rd[5:4], sl ? 2'b01 : 2'b10);
      end
      vph_host_model_i.rise();
      chk("ready_back", ready, 1'b1);
   endtask

   // cut a hang short
   initial begin
      repeat (100000) @(posedge pclk);
      miscompares++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      serial_mode_sel = 1'b0;
      host_mode_sel = 1'b1;
      miscompares = 0;
      samples_checked = 0;
      cyc = 0;
      seed = 32'h00000063;
      exp_lpf = 1'b0;
      repeat (2) @(posedge pclk);
      chk("standby", {busy_n, ready, live, osc, lpf, a_oe_n}, 6'h31);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("running", {live, osc}, 2'b11);
      apb(1'b0, vph_pkg::OFF_STATUS, 32'h0);
      chk("status", rd[9:0], 10'h00B);
      apb(1'b0, vph_pkg::OFF_PLAY_LEN, 32'h0);
      chk("len_rst", rd, {16'h0000, vph_pkg::PLAY_LEN_RST});
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      apb(1'b1, vph_pkg::OFF_PLAY_LEN, 32'h00000040);
      // phrases: both ends of the code range, then random
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         a = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : seed[6:0];
         l = seed[7];
         strobe(a, 1'b0, l);
         apb(1'b0, vph_pkg::OFF_PHRASE, 32'h0);
         chk("phrase", rd, phrase_exp(a, l));
         n = 0;
         while (busy_n !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
         end
         chk("busy_len", (cyc - t0 >= 64) && (cyc - t0 <= 76), 1'b1);
      end
      // stop request ends a running phrase on channel 1 at once
      strobe(7'h2A, 1'b0, 1'b1);
      apb(1'b1, vph_pkg::OFF_STOP, 32'h00000001);
      repeat (2) @(posedge pclk);
      chk("stopped", busy_n, 1'b1);
      // every command op, route moves both ways
      for (int op = 1; op < 5; op++) begin
         seed = xs(seed);
         a = {op[1:0], seed[4:0]};
         exp_lpf = lpf_exp(op[1:0], exp_lpf);
         strobe(a, 1'b1, 1'b1);
         chk("route", lpf, exp_lpf);
         chk("no_play", busy_n, 1'b1);
         apb(1'b0, vph_pkg::OFF_COMMAND, 32'h0);
         chk("command", rd, {25'h0, a});
         chk("port_off", {a_oe_n, b_oe_n}, 2'b11);
      end
      // strobe refused with host mode off
      host_mode_sel <= 1'b0;
      repeat (6) @(posedge pclk);
      vph_host_model_i.fall(7'h15, 1'b0, 1'b1);
      repeat (8) @(posedge pclk);
      chk("refused", {ready, busy_n}, 2'b11);
      vph_host_model_i.rise();
      host_mode_sel <= 1'b1;
      // serial mode: silence codes drive lines 2 and 3
      serial_mode_sel <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("port_on", {a_oe_n, b_oe_n}, 2'b00);
      for (int s = 3; s >= 0; s -= 3) begin
         vph_host_model_i.ser({3'b110, 3'b000, s[1:0]});
         strobe(7'h00, 1'b1, 1'b1);
         chk("port_lvl", {b_w, a_w}, s[1:0]);
      end
      seed = xs(seed);
      a = seed[6:0];
      vph_host_model_i.ser({1'b0, a});
      strobe(a, 1'b0, 1'b0);
      apb(1'b0, vph_pkg::OFF_PHRASE, 32'h0);
      chk("ser_phrase", rd, phrase_exp(a, 1'b0));
      // reset while playing
      presetn <= 1'b0;
      @(posedge pclk);
      @(posedge pclk);
      chk("rst_mid", {busy_n, ready, live, osc, a_oe_n, b_oe_n}, 6'h33);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(1'b0, vph_pkg::OFF_PLAY_LEN, 32'h0);
      chk("len_reinit", rd, {16'h0000, vph_pkg::PLAY_LEN_RST});
      chk("host_wait", stuck, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
